// File: shared/alarm_trim_consts.vh
// register indices, field positions and reset values for the alarm and trim slice
`ifndef ALARM_TRIM_CONSTS_VH
`define ALARM_TRIM_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_ALARM_SUMMARY 10'h2c0
`define IDX_ALARM_EVENT_FLAGS 10'h2c1
`define IDX_ALARM_SOURCE_MASK 10'h2c2
`define IDX_LANE_BUFFER_ALARM_FLAGS 10'h2c4
`define IDX_CAL_CONTROL 10'h2c8
`define IDX_CAL_STATUS 10'h2c9
`define IDX_CORE0_OFFSET_TRIM 10'h330
`define IDX_CORE1_OFFSET_TRIM 10'h332
`define IDX_CORE2_INPUT_A_OFFSET_TRIM 10'h334

// alarm event / mask bit positions
`define BIT_LANE_BUFFER 5
`define BIT_SERIALIZER_LOCK 4
`define BIT_LINK_STATE 3
`define BIT_REALIGNMENT 2
`define BIT_DIVIDER_MISMATCH 0

// calibration control bit positions
`define BIT_BACKGROUND_CAL 0
`define BIT_OFFSET_CAL 1
`define BIT_CONTINUOUS_OFFSET_CAL 2

// reset values
`define RST_ALARM_SOURCE_MASK 8'h3f
`define RST_ALARM_EVENT_FLAGS 6'h3f
`define RST_LANE_BUFFER_ALARM_FLAGS 8'hff
`define RST_OFFSET_TRIM 16'h0000
`define RST_CAL_CONTROL 3'h0

// field width of an offset trim value
`define TRIM_VALUE_W 12

// axi response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: verilog/sticky_flag.v
// vector of sticky flags: hardware sets, software clears by writing one
`timescale 1ns/1ps
module sticky_flag #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] set, // level or pulse per flag
    input wire [WIDTH-1:0] clear, // one-cycle clear per flag
    output reg [WIDTH-1:0] flag
);
    // set wins over clear so an event in the clearing cycle is kept
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag <= RESET_VALUE;
        end else begin
            flag <= (flag & ~clear) | set;
        end
    end
endmodule // sticky_flag

// File: verilog/alarm_mask_offset_trim_regs.v
// alarm mask, lane alarm and offset trim register slice behind an axi4-lite slave
//
// Contract
// RULE1 - mask bit 5 hides lane buffer alarm
// RULE2 - mask bit 4 hides serializer lock alarm
// RULE3 - mask bit 3 hides link state alarm
// RULE4 - mask bit 2 hides realignment alarm
// RULE5 - mask bit 0 hides divider mismatch alarm
// RULE6 - mask register resets to 0x3f
// RULE7 - software writes reserved bits with reset values
// RULE8 - lane i buffer fault sets lane bit i
// RULE9 - writing one clears lane bit, zero keeps
// RULE10 - persisting lane fault sets bit again immediately
// RULE11 - clearing status bit 5 clears all lanes
// RULE12 - lane alarm register resets to 0xff
// RULE13 - core 0 uses unsigned bits 11:0
// RULE14 - trim power-up value comes from fuses
// RULE15 - no trim access during offset calibration
// RULE16 - foreground offset cal: wait for done
// RULE17 - continuous background offset cal: never access
// RULE18 - non-continuous background: bgos stays zero
// RULE19 - spare cores still offset-calibrated in foreground
// RULE20 - other configurations: trim access immediately allowed
// RULE21 - core 1 uses its bits 11:0
// RULE22 - core 2 applies trim only on input a
// RULE23 - summary reads one on any unmasked alarm
// RULE24 - alarm flags set on event, cleared by one
// RULE25 - trim values reach datapath whole, synchronously
`timescale 1ns/1ps
`include "alarm_trim_consts.vh"
module alarm_mask_offset_trim_regs #(
    parameter ADDR_W = 12, // byte address width
    parameter LANES = 8 // serial lanes with elastic buffers
) (
    input wire aclk,
    input wire aresetn,
    // axi4-lite slave
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // alarm sources, high while the condition holds
    input wire [LANES-1:0] lane_buffer_fault,
    input wire serializer_lock_alarm,
    input wire link_state_alarm,
    input wire realignment_alarm,
    input wire divider_mismatch_alarm,
    // fuse storage
    input wire fuse_load,
    input wire [`TRIM_VALUE_W-1:0] fuse_core0_offset,
    input wire [`TRIM_VALUE_W-1:0] fuse_core1_offset,
    input wire [`TRIM_VALUE_W-1:0] fuse_core2_input_a_offset,
    // calibration engine handshake
    input wire offset_cal_busy,
    input wire foreground_cal_done,
    input wire core2_sampling_first_input,
    // outputs to the engine and datapath
    output reg alarm_summary,
    output reg background_cal_enable,
    output reg offset_cal_enable,
    output reg continuous_offset_cal_enable,
    output reg spare_offset_cal_in_foreground,
    output reg trim_access_ok,
    output reg [`TRIM_VALUE_W-1:0] core0_offset,
    output reg [`TRIM_VALUE_W-1:0] core1_offset,
    output reg [`TRIM_VALUE_W-1:0] core2_offset,
    output reg core2_offset_active
);

    // ---------------- write channel ----------------
    reg aw_full; // write address held
    reg w_full; // write data held
    reg [9:0] aw_idx; // held word index
    reg [31:0] w_data; // held write data
    reg [3:0] w_strb; // held byte strobes
    wire write_fire; // one-cycle commit of a write
    reg write_hit; // decoded index is mapped

    assign write_fire = aw_full & w_full & ~s_axi_bvalid;

    // address and data taken in either order, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_idx <= 10'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx <= s_axi_awaddr[11:2];
                aw_full <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_full <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (write_fire) begin
                // unmapped writes are dropped and answered slverr
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
                aw_full <= 1'b0;
                w_full <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // per-register write strobes
    wire wr_status = write_fire && aw_idx == `IDX_ALARM_EVENT_FLAGS && w_strb[0];
    wire wr_mask = write_fire && aw_idx == `IDX_ALARM_SOURCE_MASK;
    wire wr_lanes = write_fire && aw_idx == `IDX_LANE_BUFFER_ALARM_FLAGS && w_strb[0];
    wire wr_cal = write_fire && aw_idx == `IDX_CAL_CONTROL;
    wire wr_trim0 = write_fire && aw_idx == `IDX_CORE0_OFFSET_TRIM;
    wire wr_trim1 = write_fire && aw_idx == `IDX_CORE1_OFFSET_TRIM;
    wire wr_trim2 = write_fire && aw_idx == `IDX_CORE2_INPUT_A_OFFSET_TRIM;

    // write-side decode of mapped indices
    always @* begin
        case (aw_idx)
            `IDX_ALARM_SUMMARY: write_hit = 1'b1; // read-only, write ignored
            `IDX_ALARM_EVENT_FLAGS: write_hit = 1'b1;
            `IDX_ALARM_SOURCE_MASK: write_hit = 1'b1;
            `IDX_LANE_BUFFER_ALARM_FLAGS: write_hit = 1'b1;
            `IDX_CAL_CONTROL: write_hit = 1'b1;
            `IDX_CAL_STATUS: write_hit = 1'b1; // read-only, write ignored
            `IDX_CORE0_OFFSET_TRIM: write_hit = 1'b1;
            `IDX_CORE1_OFFSET_TRIM: write_hit = 1'b1;
            `IDX_CORE2_INPUT_A_OFFSET_TRIM: write_hit = 1'b1;
            default: write_hit = 1'b0;
        endcase
    end

    // ---------------- alarm logic ----------------
    reg [7:0] alarm_source_mask; // all bits stored, reserved ones included
    wire [5:0] alarm_event_flags; // sticky alarm status
    wire [LANES-1:0] lane_buffer_alarm_flags; // sticky per-lane alarms
    wire lane_buffer_alarm = |lane_buffer_fault; // any lane in fault
    wire [5:0] status_set; // event vector in status layout
    wire [5:0] status_clear; // software clear vector
    wire [LANES-1:0] lane_clear; // software clear of lane flags

    // bit 1 is reserved: no event sets it, only reset does; software clears it
    assign status_set = {lane_buffer_alarm, serializer_lock_alarm, link_state_alarm,
                         realignment_alarm, 1'b0, divider_mismatch_alarm}; // [RULE24]
    assign status_clear = wr_status ? w_data[5:0] : 6'h00; // [RULE24]

    // lane clear by its own bits, or all at once via status bit 5
    assign lane_clear = (wr_lanes ? w_data[LANES-1:0] : {LANES{1'b0}}) // [RULE9]
        | ((wr_status && w_data[`BIT_LANE_BUFFER]) ? {LANES{1'b1}} : {LANES{1'b0}}); // [RULE11]

    // sticky status flags, reset all set
    sticky_flag #(
        .WIDTH(6),
        .RESET_VALUE(`RST_ALARM_EVENT_FLAGS)
    ) u_event_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(status_set),
        .clear(status_clear),
        .flag(alarm_event_flags)
    );

    // lane flags; a held fault re-sets over the clear at once
    sticky_flag #(
        .WIDTH(LANES),
        .RESET_VALUE({LANES{1'b1}}) // [RULE12]
    ) u_lane_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(lane_buffer_fault), // [RULE8] [RULE10]
        .clear(lane_clear),
        .flag(lane_buffer_alarm_flags)
    );

    // mask register; reserved bits stored as written
    always @(posedge aclk) begin
        if (!aresetn) begin
            alarm_source_mask <= `RST_ALARM_SOURCE_MASK; // [RULE6]
        end else if (wr_mask && w_strb[0]) begin
            alarm_source_mask <= w_data[7:0];
        end
    end

    // unmasked alarms; reserved bit 1 never contributes
    wire [5:0] unmasked;
    assign unmasked[`BIT_LANE_BUFFER] = alarm_event_flags[`BIT_LANE_BUFFER]
        & ~alarm_source_mask[`BIT_LANE_BUFFER]; // [RULE1]
    assign unmasked[`BIT_SERIALIZER_LOCK] = alarm_event_flags[`BIT_SERIALIZER_LOCK]
        & ~alarm_source_mask[`BIT_SERIALIZER_LOCK]; // [RULE2]
    assign unmasked[`BIT_LINK_STATE] = alarm_event_flags[`BIT_LINK_STATE]
        & ~alarm_source_mask[`BIT_LINK_STATE]; // [RULE3]
    assign unmasked[`BIT_REALIGNMENT] = alarm_event_flags[`BIT_REALIGNMENT]
        & ~alarm_source_mask[`BIT_REALIGNMENT]; // [RULE4]
    assign unmasked[1] = 1'b0;
    assign unmasked[`BIT_DIVIDER_MISMATCH] = alarm_event_flags[`BIT_DIVIDER_MISMATCH]
        & ~alarm_source_mask[`BIT_DIVIDER_MISMATCH]; // [RULE5]

    // summary registered so the output comes from a flop; one cycle behind flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            alarm_summary <= 1'b0;
        end else begin
            alarm_summary <= |unmasked; // [RULE23]
        end
    end

    // ---------------- calibration controls ----------------
    reg [2:0] cal_control; // bg, os, continuous offset

    // control bits for the external calibration engine
    always @(posedge aclk) begin
        if (!aresetn) begin
            cal_control <= `RST_CAL_CONTROL;
        end else if (wr_cal && w_strb[0]) begin
            cal_control <= w_data[2:0];
        end
    end

    // registered copies out to the engine and the access-window flag
    always @(posedge aclk) begin
        if (!aresetn) begin
            background_cal_enable <= 1'b0;
            offset_cal_enable <= 1'b0;
            continuous_offset_cal_enable <= 1'b0;
            spare_offset_cal_in_foreground <= 1'b0;
            trim_access_ok <= 1'b0;
        end else begin
            background_cal_enable <= cal_control[`BIT_BACKGROUND_CAL];
            offset_cal_enable <= cal_control[`BIT_OFFSET_CAL];
            continuous_offset_cal_enable <= cal_control[`BIT_CONTINUOUS_OFFSET_CAL];
            // spares get the foreground offset step when offsets are calibrated in non-continuous background mode
            spare_offset_cal_in_foreground <= cal_control[`BIT_OFFSET_CAL]
                & cal_control[`BIT_BACKGROUND_CAL]
                & ~cal_control[`BIT_CONTINUOUS_OFFSET_CAL]; // [RULE19] [RULE18]
            // advisory only: software must honour it, the slave does not block
            if (offset_cal_busy) begin
                trim_access_ok <= 1'b0; // [RULE15]
            end else if (cal_control[`BIT_BACKGROUND_CAL]
                         && cal_control[`BIT_CONTINUOUS_OFFSET_CAL]) begin
                trim_access_ok <= 1'b0; // [RULE17]
            end else if (cal_control[`BIT_OFFSET_CAL]) begin
                trim_access_ok <= foreground_cal_done; // [RULE16]
            end else begin
                trim_access_ok <= 1'b1; // [RULE20]
            end
        end
    end

    // ---------------- offset trims ----------------
    reg [15:0] core0_offset_trim; // bits 15:12 reserved, stored
    reg [15:0] core1_offset_trim;
    reg [15:0] core2_input_a_offset_trim;

    // byte-lane write of a 16-bit trim register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    // fuse load wins over a bus write in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            core0_offset_trim <= `RST_OFFSET_TRIM;
            core1_offset_trim <= `RST_OFFSET_TRIM;
            core2_input_a_offset_trim <= `RST_OFFSET_TRIM;
        end else if (fuse_load) begin
            core0_offset_trim <= {4'h0, fuse_core0_offset}; // [RULE14]
            core1_offset_trim <= {4'h0, fuse_core1_offset}; // [RULE14]
            core2_input_a_offset_trim <= {4'h0, fuse_core2_input_a_offset}; // [RULE14]
        end else begin
            if (wr_trim0) begin
                core0_offset_trim <= merge16(core0_offset_trim, w_data, w_strb);
            end
            if (wr_trim1) begin
                core1_offset_trim <= merge16(core1_offset_trim, w_data, w_strb);
            end
            if (wr_trim2) begin
                core2_input_a_offset_trim <= merge16(core2_input_a_offset_trim, w_data, w_strb);
            end
        end
    end

    // datapath copies: all 12 bits move on one edge, never half a value
    always @(posedge aclk) begin
        if (!aresetn) begin
            core0_offset <= 12'h000;
            core1_offset <= 12'h000;
            core2_offset <= 12'h000;
            core2_offset_active <= 1'b0;
        end else begin
            core0_offset <= core0_offset_trim[11:0]; // [RULE13] [RULE25]
            core1_offset <= core1_offset_trim[11:0]; // [RULE21] [RULE25]
            // other inputs of core 2 use trims held outside this slice
            if (core2_sampling_first_input) begin
                core2_offset <= core2_input_a_offset_trim[11:0]; // [RULE22] [RULE25]
                core2_offset_active <= 1'b1;
            end else begin
                core2_offset <= 12'h000;
                core2_offset_active <= 1'b0;
            end
        end
    end

    // ---------------- read channel ----------------
    reg [31:0] read_word; // data for the requested index
    reg read_hit; // requested index is mapped
    wire [9:0] ar_idx = s_axi_araddr[11:2];

    // reads have no side effects; bits above each register's stored width read zero
    always @* begin
        read_word = 32'h00000000;
        read_hit = 1'b1;
        case (ar_idx)
            `IDX_ALARM_SUMMARY: read_word[0] = alarm_summary;
            `IDX_ALARM_EVENT_FLAGS: read_word[5:0] = alarm_event_flags;
            `IDX_ALARM_SOURCE_MASK: read_word[7:0] = alarm_source_mask;
            `IDX_LANE_BUFFER_ALARM_FLAGS: read_word[LANES-1:0] = lane_buffer_alarm_flags;
            `IDX_CAL_CONTROL: read_word[2:0] = cal_control;
            `IDX_CAL_STATUS: read_word[2:0] = {trim_access_ok, foreground_cal_done,
                                              offset_cal_busy};
            `IDX_CORE0_OFFSET_TRIM: read_word[15:0] = core0_offset_trim;
            `IDX_CORE1_OFFSET_TRIM: read_word[15:0] = core1_offset_trim;
            `IDX_CORE2_INPUT_A_OFFSET_TRIM: read_word[15:0] = core2_input_a_offset_trim;
            default: read_hit = 1'b0;
        endcase
    end

    // one read at a time; data one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_word;
                s_axi_rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // software must keep reserved bits at reset values; stored as written [RULE7]

endmodule // alarm_mask_offset_trim_regs

// File: verification/alarm_trim_checker.sv
// concurrent checks on the ports of the alarm and trim register slice
`timescale 1ns/1ps
module alarm_trim_checker (
    input aclk,
    input aresetn,
    input s_axi_awvalid,
    input s_axi_awready,
    input s_axi_wvalid,
    input s_axi_wready,
    input s_axi_bvalid,
    input s_axi_arvalid,
    input s_axi_arready,
    input [31:0] s_axi_rdata,
    input s_axi_rvalid,
    input s_axi_rready,
    input offset_cal_busy,
    input foreground_cal_done,
    input core2_sampling_first_input,
    input background_cal_enable,
    input offset_cal_enable,
    input continuous_offset_cal_enable,
    input spare_offset_cal_in_foreground,
    input trim_access_ok,
    input fuse_load,
    input [11:0] core0_offset,
    input [11:0] core2_offset,
    input core2_offset_active
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // access flag: busy, done and cal mode, one edge late
    property p_trim_ok;
        $past(aresetn) |-> trim_access_ok == (!$past(offset_cal_busy)
            && !(background_cal_enable && continuous_offset_cal_enable)
            && (!offset_cal_enable || $past(foreground_cal_done)));
    endproperty
    a_trim_ok: assert property (p_trim_ok) else $error("trim access flag");
    // spares only in non-continuous background mode
    property p_spare;
        spare_offset_cal_in_foreground == (offset_cal_enable && background_cal_enable
            && !continuous_offset_cal_enable);
    endproperty
    a_spare: assert property (p_spare) else $error("spare offset cal");
    // core 2 gets zero off the first input
    property p_core2_gate;
        !core2_offset_active |-> core2_offset == 12'h000;
    endproperty
    a_core2_gate: assert property (p_core2_gate) else $error("core2 offset leak");
    property p_core2_sel;
        $past(aresetn) |-> core2_offset_active == $past(core2_sampling_first_input);
    endproperty
    a_core2_sel: assert property (p_core2_sel) else $error("core2 select");
    // moves only after a write commit or fuse load
    property p_core0_change;
        $changed(core0_offset) |-> $past(s_axi_bvalid) || $past(fuse_load, 2);
    endproperty
    a_core0_change: assert property (p_core0_change) else $error("core0 moved");
    // answer two edges after both taken together
    property p_write_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response late");
    property p_write_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_write_refuse: assert property (p_write_refuse) else $error("write taken while busy");
    property p_read_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_ans: assert property (p_read_ans) else $error("read answer late");
    // read data holds while the master stalls
    property p_read_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data dropped");

    c_write: cover property (s_axi_bvalid && !s_axi_awready);
    c_offset_ok: cover property (offset_cal_enable && trim_access_ok);
    c_core2: cover property (core2_offset_active);
endmodule // alarm_trim_checker

bind alarm_mask_offset_trim_regs alarm_trim_checker i_alarm_trim_checker (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .offset_cal_busy, .foreground_cal_done, .core2_sampling_first_input,
    .background_cal_enable, .offset_cal_enable, .continuous_offset_cal_enable,
    .spare_offset_cal_in_foreground, .trim_access_ok, .fuse_load, .core0_offset,
    .core2_offset, .core2_offset_active);

// File: verification/alarm_mask_offset_trim_regs_tb_top.sv
// self-checking bench for the alarm mask, lane alarm and offset trim slice
`timescale 1ns/1ps
`include "alarm_trim_consts.vh"
module alarm_mask_offset_trim_regs_tb_top;
    localparam [11:0] A_STAT = {`IDX_ALARM_EVENT_FLAGS, 2'b00},
        A_MASK = {`IDX_ALARM_SOURCE_MASK, 2'b00}, A_LANE = {`IDX_LANE_BUFFER_ALARM_FLAGS, 2'b00},
        A_CAL = {`IDX_CAL_CONTROL, 2'b00}, A_T0 = {`IDX_CORE0_OFFSET_TRIM, 2'b00},
        A_T1 = {`IDX_CORE1_OFFSET_TRIM, 2'b00}, A_T2 = {`IDX_CORE2_INPUT_A_OFFSET_TRIM, 2'b00};
    localparam [11:0] F0 = 12'h5a5, F1 = 12'h0f1, F2 = 12'h7e7; // fuse contents
    reg aclk = 1'b0; // 100 MHz
    reg aresetn = 1'b0;
    reg [11:0] awaddr = 12'h000, araddr = 12'h000;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg [31:0] wdata = 32'h0;
    reg [3:0] wstrb = 4'hf;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    reg [7:0] lane_in = 8'h00; // lane buffer faults
    reg [5:0] src = 6'h00; // other sources, by status bit position
    reg fuse_load = 1'b0, busy = 1'b0, done = 1'b0, sel = 1'b0;
    wire sum, bg, os, bgos, spare, ok, act;
    wire [11:0] c0, c1, c2;
    integer failures = 0, samples_checked = 0;
    reg [31:0] data; // last read word
    reg [1:0] resp; // last response code

    alarm_mask_offset_trim_regs i_alarm_mask_offset_trim_regs (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .lane_buffer_fault(lane_in), .serializer_lock_alarm(src[4]),
        .link_state_alarm(src[3]), .realignment_alarm(src[2]), .divider_mismatch_alarm(src[0]),
        .fuse_load(fuse_load), .fuse_core0_offset(F0), .fuse_core1_offset(F1),
        .fuse_core2_input_a_offset(F2), .offset_cal_busy(busy), .foreground_cal_done(done),
        .core2_sampling_first_input(sel), .alarm_summary(sum), .background_cal_enable(bg),
        .offset_cal_enable(os), .continuous_offset_cal_enable(bgos),
        .spare_offset_cal_in_foreground(spare), .trim_access_ok(ok), .core0_offset(c0),
        .core1_offset(c1), .core2_offset(c2), .core2_offset_active(act));

    // free-running clock
    always #5 aclk = ~aclk;

    task wrap_up;
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input string name, input [31:0] exp, input [31:0] got);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // address and data offered together, all bytes; bready held up
    task wr(input [11:0] a, input [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    // rready late on purpose: data must stand
    task rd(input [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b1;
        @(posedge aclk);
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task rd_chk(input [11:0] a, input [31:0] exp, input string name);
        rd(a);
        chk(name, exp, data);
    endtask

    task t_reset;
        rd_chk(A_MASK, 32'h3f, "mask reset");
        rd_chk(A_LANE, 32'hff, "lane reset");
        chk("summary reset", 32'h0, {31'h0, sum});
    endtask

    // each source hidden while masked, visible once unmasked
    task t_mask;
        integer i, b;
        wr(A_STAT, 32'h3f);
        for (i = 0; i < 5; i = i + 1) begin
            b = (i == 4) ? 0 : 5 - i;
            lane_in <= {7'h0, b == 5};
            src[b] <= 1'b1;
            @(posedge aclk);
            lane_in <= 8'h00;
            src <= 6'h00;
            repeat (3) @(posedge aclk);
            chk("masked", 32'h0, {31'h0, sum});
            wr(A_MASK, 32'h3f ^ (32'h1 << b));
            repeat (2) @(posedge aclk);
            chk("unmasked", 32'h1, {31'h0, sum});
            wr(A_STAT, 32'h1 << b);
            repeat (2) @(posedge aclk);
            chk("cleared", 32'h0, {31'h0, sum});
            wr(A_MASK, 32'h3f);
        end
    endtask

    task t_lanes;
        wr(A_LANE, 32'hff);
        lane_in <= 8'h08;
        @(posedge aclk);
        lane_in <= 8'h00;
        rd_chk(A_LANE, 32'h08, "lane set");
        wr(A_LANE, 32'hf7);
        rd_chk(A_LANE, 32'h08, "zero keeps");
        wr(A_LANE, 32'h08);
        rd_chk(A_LANE, 32'h00, "one clears");
        lane_in <= 8'h40;
        wr(A_LANE, 32'h40);
        rd_chk(A_LANE, 32'h40, "persisting");
        lane_in <= 8'h24;
        @(posedge aclk);
        lane_in <= 8'h00;
        wr(A_STAT, 32'h20);
        rd_chk(A_LANE, 32'h00, "status clear");
    endtask

    task t_trims;
        wr(A_T0, 32'h0abc);
        wr(A_T1, 32'h0123);
        wr(A_T2, 32'h0456);
        repeat (3) @(posedge aclk);
        chk("core0", 32'habc, {20'h0, c0});
        chk("core1", 32'h123, {20'h0, c1});
        chk("core2 off", 32'h0, {19'h0, act, c2});
        sel <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("core2 on", 32'h1456, {19'h0, act, c2});
        rd_chk(A_T0, 32'h0abc, "trim0");
        fuse_load <= 1'b1;
        @(posedge aclk);
        fuse_load <= 1'b0;
        rd_chk(A_T1, {20'h0, F1}, "fuse1");
        chk("core0 fuse", {20'h0, F0}, {20'h0, c0});
        chk("core2 fuse", {20'h0, F2}, {20'h0, c2});
    endtask

    // mode in c[3:1], done in c[0]
    task t_cal;
        integer c, e;
        for (c = 0; c < 16; c = c + 1) begin
            done <= c[0];
            wr(A_CAL, c >> 1);
            repeat (3) @(posedge aclk);
            e = (c[1] & c[3]) ? 0 : (c[2] ? c[0] : 1);
            chk("enables", c >> 1, {29'h0, bgos, os, bg});
            chk("spare", {31'h0, c[3:1] == 3'h3}, {31'h0, spare});
            chk("access", e, {31'h0, ok});
        end
        busy <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("busy", 32'h0, {31'h0, ok});
        busy <= 1'b0;
    endtask

    task t_unmapped;
        rd(12'hffc);
        chk("unmapped rd", 32'h2, {data[29:0], resp});
        wr(12'hffc, 32'h1);
        chk("unmapped wr", 32'h2, {30'h0, resp});
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_mask;
        t_lanes;
        t_trims;
        t_cal;
        t_unmapped;
        wrap_up;
    end

    // watchdog far past the run length
    initial begin
        repeat (20000) @(posedge aclk);
        failures = failures + 1;
        wrap_up;
    end
endmodule // alarm_mask_offset_trim_regs_tb_top
